// ---- logic/cic_core.sv ----
// Core interrupt controller: flags, enables, entry/return sequencing,
// external pin edge detect, wake request and shadow context.
// Assumes the sequencer asserts instrCycleEnd once per instruction cycle at
// Q4 and supplies the live context; bit pulses come from the same clock.
//
// Operation
// - Any reset clears all enables so no interrupt can be taken.
// - Source needs global and own enable; peripherals also need group enable.
// - Flags set on events regardless of any enable bit.
// - Taking interrupt flushes prefetched instruction and clears global enable.
// - Entry pushes PC to stack and loads vector 0004h.
// - With global enable clear, flags only; pending flags vector when set.
// - Return pops address, restores shadowed context, sets global enable.
// - Latency 3-4 cycles synchronous, 3-5 asynchronous.
// - Latency independent of one- or two-cycle current instruction.
// - Pin flag set during Q4-Q1 (here set on any phase), sampled once per cycle at Q1.
// - Wake vectors if global enable set, else resumes after sleep.
// - Instruction after sleep always executes before vectoring.
// - External pin is async edge source gated by its own enable.
// - Polarity bit set selects rising edge, clear selects falling.
// - Valid edge sets pin flag; with enables redirects to vector.
// - Entry copies W, bank, pointers, PC high latch, status less TO/PD.
// - Exit reloads shadowed registers, discarding changes in the routine.
// - Shadows readable and writable in bank 31; written values restored.
// - Combined change flag read-only, clears when all change flags clear.
`timescale 1ns/10ps
module cic_core
    import cic_pkg::*;
(
    // Clock and reset
    input wire logic clock,
    input wire logic sys_rst,
    // Sequencer timing and events
    input wire logic [1:0] phase,
    input wire logic instrCycleEnd,
    input wire logic sleeping,
    input wire logic returnFromIsr,
    input wire logic [14:0] currentPc,
    // Software writes of enable and flag bits
    input wire logic ctrlWe,
    input wire logic [7:0] ctrlWdata,
    input wire logic edgeWe,
    input wire logic edgeWdata,
    input wire logic periphEnWe,
    input wire logic [CIC_PERIPH_N-1:0] periphEnWdata,
    input wire logic periphFlagWe,
    input wire logic [CIC_PERIPH_N-1:0] periphFlagWdata,
    // Event sources
    input wire logic extPin,
    input wire logic timerOvf,
    input wire logic [CIC_PERIPH_N-1:0] periphEvent,
    input wire logic changeFlagsAny,
    // Live context and shadow access
    input wire cic_ctx_t liveCtx,
    input wire cic_shadow_acc_t shadowAcc,
    // Outputs to sequencer
    output logic flushPrefetch,
    output logic pushPc,
    output logic [14:0] pushData,
    output logic loadPc,
    output logic [14:0] loadPcData,
    output logic restoreCtx,
    output cic_ctx_t restoreData,
    output logic irqRequest,
    output logic wakeRequest,
    // Register views
    output logic [7:0] coreIrqControl,
    output logic pinEdgePolarity,
    output logic [CIC_PERIPH_N-1:0] periphEnableRegs,
    output logic [CIC_PERIPH_N-1:0] periphFlagRegs,
    output logic [7:0] shadowRdata
);

    // ------------------------------------------------------------
    // Enable and flag registers
    // ------------------------------------------------------------
    logic globalIrqEnable_q, periphIrqEnable_q, timerIrqEnable_q;
    logic pinIrqEnable_q, changeIrqEnable_q;
    logic timerIrqFlag_q, pinIrqFlag_q, changeIrqFlag_q;
    logic pinEdgePolarity_q;
    logic [CIC_PERIPH_N-1:0] periphEn_q, periphFlag_q;
    logic entering;
    cic_state_t state_q;

    // Global enable: cleared on entry, set on return, else software
    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
            globalIrqEnable_q <= 1'b0;
        else if (entering)
            globalIrqEnable_q <= 1'b0;
        else if (returnFromIsr)
            globalIrqEnable_q <= 1'b1;
        else if (ctrlWe)
            globalIrqEnable_q <= ctrlWdata[7];
    end

    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            periphIrqEnable_q <= 1'b0;
            timerIrqEnable_q <= 1'b0;
            pinIrqEnable_q <= 1'b0;
            changeIrqEnable_q <= 1'b0;
            periphEn_q <= '0;
        end
        else
        begin
            if (ctrlWe)
            begin
                periphIrqEnable_q <= ctrlWdata[6];
                timerIrqEnable_q <= ctrlWdata[5];
                pinIrqEnable_q <= ctrlWdata[4];
                changeIrqEnable_q <= ctrlWdata[3];
            end
            if (periphEnWe)
                periphEn_q <= periphEnWdata;
        end
    end

    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
            pinEdgePolarity_q <= 1'b1;
        else if (edgeWe)
            pinEdgePolarity_q <= edgeWdata;
    end

    // ------------------------------------------------------------
    // External pin: synchronise, edge detect
    // ------------------------------------------------------------
    logic pinMeta_q, pinSync_q, pinPrev_q;
    logic pinEdge;

    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            pinMeta_q <= 1'b0;
            pinSync_q <= 1'b0;
            pinPrev_q <= 1'b0;
        end
        else
        begin
            pinMeta_q <= extPin;
            pinSync_q <= pinMeta_q;
            pinPrev_q <= pinSync_q;
        end
    end

    // Rising when polarity set, falling when clear
    assign pinEdge = pinEdgePolarity_q ? (pinSync_q & ~pinPrev_q)
                                       : (~pinSync_q & pinPrev_q);

    // ------------------------------------------------------------
    // Flags: event set wins over software clear
    // ------------------------------------------------------------
    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            timerIrqFlag_q <= 1'b0;
            pinIrqFlag_q <= 1'b0;
            periphFlag_q <= '0;
        end
        else
        begin
            if (timerOvf)
                timerIrqFlag_q <= 1'b1;
            else if (ctrlWe)
                timerIrqFlag_q <= ctrlWdata[2];
            if (pinEdge)
                pinIrqFlag_q <= 1'b1;
            else if (ctrlWe)
                pinIrqFlag_q <= ctrlWdata[1];
            if (periphFlagWe)
                periphFlag_q <= periphFlagWdata | periphEvent;
            else
                periphFlag_q <= periphFlag_q | periphEvent;
        end
    end

    // Read-only mirror of the per-pin change flags
    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
            changeIrqFlag_q <= 1'b0;
        else
            changeIrqFlag_q <= changeFlagsAny;
    end

    // ------------------------------------------------------------
    // Request forming
    // ------------------------------------------------------------
    logic coreAny, periphAny, srcAny, reqLive, reqSampled_q;

    assign coreAny = (timerIrqEnable_q & timerIrqFlag_q)
                   | (pinIrqEnable_q & pinIrqFlag_q)
                   | (changeIrqEnable_q & changeIrqFlag_q);
    assign periphAny = periphIrqEnable_q & |(periphEn_q & periphFlag_q);
    assign srcAny = coreAny | periphAny;
    assign reqLive = globalIrqEnable_q & srcAny;

    // Sampled once per instruction cycle at Q1
    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
            reqSampled_q <= 1'b0;
        else if (phase == CIC_PHASE_Q1)
            reqSampled_q <= reqLive;
    end

    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            irqRequest <= 1'b0;
            wakeRequest <= 1'b0;
        end
        else
        begin
            irqRequest <= reqLive;
            wakeRequest <= srcAny;
        end
    end

    // ------------------------------------------------------------
    // Entry sequencer counted in instruction cycles
    // ------------------------------------------------------------
    logic [1:0] cycCnt_q;

    // Entry only at a cycle boundary, never mid-sleep, so a two-cycle
    // instruction and the post-sleep instruction complete first
    assign entering = (state_q == CIC_RUN) && reqSampled_q && globalIrqEnable_q
                      && instrCycleEnd && !sleeping;

    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            state_q <= CIC_RUN;
            cycCnt_q <= '0;
        end
        else
        begin
            unique case (state_q)
                CIC_RUN:
                    if (entering)
                    begin
                        state_q <= CIC_FLUSH;
                        cycCnt_q <= CIC_ENTRY_CNT;
                    end
                CIC_FLUSH:
                    if (instrCycleEnd)
                    begin
                        cycCnt_q <= 2'(cycCnt_q - 2'h1);
                        if (cycCnt_q == 2'h1)
                            state_q <= CIC_VECTOR;
                    end
                CIC_VECTOR:
                    state_q <= CIC_RUN;
                default:
                    state_q <= CIC_RUN;
            endcase
        end
    end

    // Entry strobes to the sequencer
    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            flushPrefetch <= 1'b0;
            pushPc <= 1'b0;
            pushData <= CIC_PC_RST;
            loadPc <= 1'b0;
            loadPcData <= CIC_PC_RST;
        end
        else
        begin
            flushPrefetch <= entering;
            pushPc <= entering;
            if (entering)
                pushData <= currentPc;
            loadPc <= (state_q == CIC_FLUSH) && instrCycleEnd
                      && (cycCnt_q == 2'h1);
            loadPcData <= CIC_VECTOR_ADDR;
        end
    end

    // ------------------------------------------------------------
    // Shadow context
    // ------------------------------------------------------------
    logic [CIC_SLOTS*8-1:0] capData, shadowAll;
    cic_ctx_t shadowCtx;
    logic [4:0] statusMasked;

    always_comb
    begin
        statusMasked = liveCtx.status;
        statusMasked[CIC_STAT_WDT_BIT] = 1'b0;
        statusMasked[CIC_STAT_SLP_BIT] = 1'b0;
    end

    assign capData = {liveCtx.indirectPtr1, liveCtx.indirectPtr0,
                      1'b0, liveCtx.pcHighLatch, 2'b00, liveCtx.bankSel,
                      liveCtx.wreg, 3'b000, statusMasked};

    assign shadowCtx.status = shadowAll[4:0];
    assign shadowCtx.wreg = shadowAll[15:8];
    assign shadowCtx.bankSel = shadowAll[21:16];
    assign shadowCtx.pcHighLatch = shadowAll[30:24];
    assign shadowCtx.indirectPtr0 = shadowAll[47:32];
    assign shadowCtx.indirectPtr1 = shadowAll[63:48];

    cic_shadow_mem u_shadow (
        .clock(clock),
        .sys_rst(sys_rst),
        .capture(entering),
        .captureData(capData),
        .swWe(shadowAcc.we & ~entering),
        .swSlot(shadowAcc.slot),
        .swWdata(shadowAcc.wdata),
        .swRdata(shadowRdata),
        .allData(shadowAll)
    );

    // Restore on return; values written in the shadow bank win
    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            restoreCtx <= 1'b0;
            restoreData <= '0;
        end
        else
        begin
            restoreCtx <= returnFromIsr;
            restoreData <= shadowCtx;
        end
    end

    // ------------------------------------------------------------
    // Register views
    // ------------------------------------------------------------
    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            coreIrqControl <= CIC_BYTE_RST;
            pinEdgePolarity <= 1'b1;
            periphEnableRegs <= '0;
            periphFlagRegs <= '0;
        end
        else
        begin
            coreIrqControl <= {globalIrqEnable_q, periphIrqEnable_q,
                               timerIrqEnable_q, pinIrqEnable_q,
                               changeIrqEnable_q, timerIrqFlag_q,
                               pinIrqFlag_q, changeIrqFlag_q};
            pinEdgePolarity <= pinEdgePolarity_q;
            periphEnableRegs <= periphEn_q;
            periphFlagRegs <= periphFlag_q;
        end
    end

endmodule

// ---- logic/cic_pkg.sv ----
// Package for the core interrupt controller: widths, vector, reset values,
// context layout and sequencer states.
// Assumes one instruction-clock domain shared with the CPU sequencer.
package cic_pkg;

    localparam int CIC_PERIPH_N = 24;
    localparam logic [14:0] CIC_VECTOR_ADDR = 15'h0004;
    localparam logic [14:0] CIC_PC_RST = 15'h0000;
    localparam logic [7:0] CIC_BYTE_RST = 8'h00;
    localparam logic [4:0] CIC_STATUS_RST = 5'h00;
    localparam logic [5:0] CIC_BANK_RST = 6'h00;
    localparam logic [15:0] CIC_PTR_RST = 16'h0000;
    // Status bit positions of watchdog expiry and sleep entry
    localparam int CIC_STAT_WDT_BIT = 4;
    localparam int CIC_STAT_SLP_BIT = 3;
    // Shadow bank number and shadow slot indices
    localparam logic [5:0] CIC_SHADOW_BANK = 6'h1f;
    localparam logic [2:0] CIC_SLOT_STATUS = 3'h0;
    localparam logic [2:0] CIC_SLOT_WREG = 3'h1;
    localparam logic [2:0] CIC_SLOT_BANK = 3'h2;
    localparam logic [2:0] CIC_SLOT_PCHI = 3'h3;
    localparam logic [2:0] CIC_SLOT_P0L = 3'h4;
    localparam logic [2:0] CIC_SLOT_P0H = 3'h5;
    localparam logic [2:0] CIC_SLOT_P1L = 3'h6;
    localparam logic [2:0] CIC_SLOT_P1H = 3'h7;
    localparam int CIC_SLOTS = 8;
    // Phase counter: four phases per instruction cycle
    localparam logic [1:0] CIC_PHASE_Q1 = 2'h0;
    localparam logic [1:0] CIC_PHASE_Q4 = 2'h3;
    localparam logic [1:0] CIC_PHASE_RST = 2'h0;
    // Vector load delay in instruction cycles after entry push
    localparam int CIC_ENTRY_CYCLES = 2;
    localparam logic [1:0] CIC_ENTRY_CNT = 2'(CIC_ENTRY_CYCLES);

    typedef struct packed {
        logic [7:0] wreg;
        logic [4:0] status;
        logic [5:0] bankSel;
        logic [6:0] pcHighLatch;
        logic [15:0] indirectPtr0;
        logic [15:0] indirectPtr1;
    } cic_ctx_t;

    typedef struct packed {
        logic we;
        logic [2:0] slot;
        logic [7:0] wdata;
    } cic_shadow_acc_t;

    typedef enum logic [1:0] {
        CIC_RUN,
        CIC_FLUSH,
        CIC_VECTOR
    } cic_state_t;

endpackage

// ---- logic/cic_shadow_mem.sv ----
// Shadow context store: eight byte slots, written on entry or by software.
// Assumes the owner never issues capture and a software write together.
`timescale 1ns/10ps
module cic_shadow_mem
    import cic_pkg::*;
(
    // Clock and reset
    input wire logic clock,
    input wire logic sys_rst,
    // Bulk capture
    input wire logic capture,
    input wire logic [CIC_SLOTS*8-1:0] captureData,
    // Single-slot software access
    input wire logic swWe,
    input wire logic [2:0] swSlot,
    input wire logic [7:0] swWdata,
    // Registered read data; combinational view of all slots
    output logic [7:0] swRdata,
    output logic [CIC_SLOTS*8-1:0] allData
);

    logic [7:0] mem_q [CIC_SLOTS];

    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            for (int i = 0; i < CIC_SLOTS; i++)
                mem_q[i] <= CIC_BYTE_RST;
        end
        else if (capture)
        begin
            for (int i = 0; i < CIC_SLOTS; i++)
                mem_q[i] <= captureData[i*8 +: 8];
        end
        else if (swWe)
        begin
            mem_q[swSlot] <= swWdata;
        end
    end

    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
            swRdata <= CIC_BYTE_RST;
        else
            swRdata <= mem_q[swSlot];
    end

    always_comb
    begin
        for (int i = 0; i < CIC_SLOTS; i++)
            allData[i*8 +: 8] = mem_q[i];
    end

endmodule

// ---- sim/cic_core_sva.sv ----
// Checker of the interrupt controller port behaviour.
// Assumes one clock domain; bound to every controller instance.
`timescale 1ns/10ps
module cic_core_sva
    import cic_pkg::*;
(
    // Clock and reset
    input wire logic clock,
    input wire logic sys_rst,
    // Watched ports
    input wire logic sleeping,
    input wire logic flushPrefetch,
    input wire logic pushPc,
    input wire logic loadPc,
    input wire logic [14:0] loadPcData,
    input wire logic restoreCtx,
    input wire logic irqRequest,
    input wire logic wakeRequest,
    input wire logic [7:0] coreIrqControl
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (sys_rst);

    a_vector_addr:
        assert property (loadPc |-> loadPcData == CIC_VECTOR_ADDR)
        else $error("vector address wrong");
    a_load_single:
        assert property (loadPc |=> !loadPc)
        else $error("vector load longer than one cycle");
    a_flush_push:
        assert property (pushPc |-> flushPrefetch && !loadPc)
        else $error("push without flush");
    a_gie_clear:
        assert property (pushPc |-> ##[1:2] !coreIrqControl[7])
        else $error("global enable not cleared on entry");
    a_entry_delay:
        assert property (pushPc |-> ##[6:9] loadPc)
        else $error("vector load not in time after push");
    a_restore_gie:
        assert property (restoreCtx |-> ##[1:2] coreIrqControl[7])
        else $error("global enable not set on return");
    a_no_gie_irq:
        assert property (!coreIrqControl[7] [*3] |-> !irqRequest)
        else $error("request while global enable clear");
    a_irq_needs_gie:
        assert property ($rose(irqRequest) |-> ##[0:1] coreIrqControl[7])
        else $error("request rose without global enable");
    a_wake_no_gie:
        assert property (coreIrqControl[4] && coreIrqControl[1]
            && $past(coreIrqControl[4] && coreIrqControl[1]) |-> wakeRequest)
        else $error("wake missing for enabled pin flag");
    a_sleep_no_push:
        assert property (sleeping && $past(sleeping, 2) |-> !pushPc)
        else $error("entry while asleep");

    c_entry: cover property (pushPc ##[6:9] loadPc);
    c_return: cover property (restoreCtx);
    c_wake: cover property (sleeping && wakeRequest);
endmodule

bind cic_core cic_core_sva cic_core_sva_inst (.clock(clock),
    .sys_rst(sys_rst), .sleeping(sleeping), .flushPrefetch(flushPrefetch),
    .pushPc(pushPc), .loadPc(loadPc), .loadPcData(loadPcData),
    .restoreCtx(restoreCtx), .irqRequest(irqRequest),
    .wakeRequest(wakeRequest), .coreIrqControl(coreIrqControl));

// ---- sim/cic_core_tb.sv ----
// Self-checking bench of the interrupt controller.
// Assumes the sequencer model and the bound checker.
`timescale 1ns/10ps
module cic_core_tb
    import cic_pkg::*;
;
    logic clock = 1'b0;
    logic sys_rst = 1'b1;
    logic slp = 1'b0, ret = 1'b0, cWe = 1'b0, eWe = 1'b0, eWd = 1'b0;
    logic pEWe = 1'b0, pFWe = 1'b0, pin = 1'b0, tOvf = 1'b0, chg = 1'b0;
    logic [7:0] cWd = 8'h00;
    logic [CIC_PERIPH_N-1:0] pEWd = '0, pEvt = '0, pEn, pFl;
    cic_ctx_t live = '0, rd, got;
    cic_shadow_acc_t sAcc = '0;
    logic flush, push, load, rCtx, irq, wake, pol, ice;
    logic [14:0] pushD, loadD, pc, pcAtPush;
    logic [1:0] phase;
    logic [7:0] ctl, sRd;
    int n_mismatch = 0;
    int comparisons = 0;
    int cycles = 0;
    int n;

    cic_core cic_core_inst (.clock(clock), .sys_rst(sys_rst),
        .phase(phase), .instrCycleEnd(ice), .sleeping(slp),
        .returnFromIsr(ret), .currentPc(pc), .ctrlWe(cWe), .ctrlWdata(cWd),
        .edgeWe(eWe), .edgeWdata(eWd), .periphEnWe(pEWe),
        .periphEnWdata(pEWd), .periphFlagWe(pFWe), .periphFlagWdata('0),
        .extPin(pin), .timerOvf(tOvf), .periphEvent(pEvt),
        .changeFlagsAny(chg), .liveCtx(live), .shadowAcc(sAcc),
        .flushPrefetch(flush), .pushPc(push), .pushData(pushD),
        .loadPc(load), .loadPcData(loadD), .restoreCtx(rCtx),
        .restoreData(rd), .irqRequest(irq), .wakeRequest(wake),
        .coreIrqControl(ctl), .pinEdgePolarity(pol),
        .periphEnableRegs(pEn), .periphFlagRegs(pFl), .shadowRdata(sRd));
    cic_seq_model cic_seq_model_inst (.clock(clock), .sys_rst(sys_rst),
        .loadPc(load), .loadPcData(loadD), .phase(phase),
        .instrCycleEnd(ice), .currentPc(pc));

    always #5 clock = ~clock;

    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task conclude();
        $display("compared %0d mismatched %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    always @(posedge clock)
    begin
        cycles++;
        if (cycles == 4000)
        begin
            n_mismatch++;
            conclude();
        end
    end

    task cyc(input int k);
        repeat (k) @(negedge clock);
    endtask

    task chk(input logic [31:0] g, input logic [31:0] e);
        comparisons++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("mismatch at %0t got %h exp %h", $time, g, e);
        end
    endtask

    task wctl(input logic [7:0] d);
        cWe = 1'b1;
        cWd = d;
        cyc(1);
        cWe = 1'b0;
        cyc(3);
    endtask

    task pulseT();
        tOvf = 1'b1;
        cyc(1);
        tOvf = 1'b0;
    endtask

    task waitLoad();
        n = 0;
        while (load !== 1'b1 && n < 40)
        begin
            if (push === 1'b1)
                pcAtPush = pc;
            cyc(1);
            n++;
        end
        chk(n < 40, 1'b1);
        chk(loadD, 15'h0004);
        chk(pushD, pcAtPush - 15'h1);
    endtask

    // Clear flags, then return and capture the restored context
    task doRet(input logic [7:0] d);
        wctl(d);
        ret = 1'b1;
        cyc(1);
        got = rd;
        chk(rCtx, 1'b1);
        ret = 1'b0;
        cyc(3);
        chk(ctl[7], 1'b1);
        cyc(12);
        chk(irq, 1'b0);
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task tReset();
        chk(pol, 1'b1);
        wctl(8'hf8);
        sys_rst = 1'b1;
        cyc(2);
        sys_rst = 1'b0;
        cyc(2);
        chk(ctl, 8'h00);
        chk(irq, 1'b0);
        $display("reset test done");
    endtask

    task tPending();
        pulseT();
        cyc(4);
        chk(ctl, 8'h04);
        chk(irq, 1'b0);
        wctl(8'ha4);
        waitLoad();
        doRet(8'h20);
        chk(ctl, 8'ha0);
        wctl(8'h00);
        $display("pending flag test done");
    endtask

    task tEntry();
        live.wreg = 8'h5a;
        live.bankSel = 6'h01;
        live.status = 5'h1f;
        wctl(8'ha0);
        pulseT();
        waitLoad();
        chk(n >= 12 && n <= 16, 1'b1);
        live.wreg = 8'h11;
        sAcc = '{1'b0, CIC_SLOT_WREG, 8'h00};
        cyc(2);
        chk(sRd, 8'h5a);
        sAcc = '{1'b1, CIC_SLOT_BANK, 8'h2a};
        cyc(1);
        sAcc.we = 1'b0;
        doRet(8'h20);
        chk(got.wreg, 8'h5a);
        chk(got.bankSel, 6'h2a);
        chk(got.status, 5'h07);
        wctl(8'h00);
        $display("entry and context test done");
    endtask

    task tGroup();
        pEWd = 24'h000001;
        pEWe = 1'b1;
        cyc(1);
        pEWe = 1'b0;
        pEvt[0] = 1'b1;
        cyc(1);
        pEvt[0] = 1'b0;
        cyc(4);
        chk(pFl[0], 1'b1);
        chk(pEn, 24'h000001);
        chk(wake, 1'b0);
        wctl(8'h40);
        chk(wake, 1'b1);
        chk(irq, 1'b0);
        wctl(8'h80);
        cyc(16);
        chk(irq, 1'b0);
        wctl(8'hc0);
        waitLoad();
        pFWe = 1'b1;
        cyc(1);
        pFWe = 1'b0;
        doRet(8'h40);
        wctl(8'h00);
        $display("peripheral group test done");
    endtask

    task tSleep();
        wctl(8'ha0);
        slp = 1'b1;
        pulseT();
        cyc(4);
        chk(wake, 1'b1);
        for (int i = 0; i < 12; i++)
        begin
            cyc(1);
            chk(push, 1'b0);
        end
        slp = 1'b0;
        waitLoad();
        doRet(8'h20);
        wctl(8'h00);
        $display("sleep wake test done");
    endtask

    task tPin();
        pin = 1'b1;
        cyc(8);
        chk(ctl[1], 1'b1);
        wctl(8'h00);
        pin = 1'b0;
        cyc(8);
        chk(ctl[1], 1'b0);
        eWe = 1'b1;
        cyc(1);
        eWe = 1'b0;
        cyc(3);
        chk(pol, 1'b0);
        pin = 1'b1;
        cyc(8);
        chk(ctl[1], 1'b0);
        pin = 1'b0;
        cyc(8);
        chk(ctl[1], 1'b1);
        wctl(8'h92);
        waitLoad();
        doRet(8'h10);
        wctl(8'h00);
        $display("pin edge test done");
    endtask

    task tChange();
        chg = 1'b1;
        cyc(4);
        chk(ctl[0], 1'b1);
        wctl(8'h00);
        chk(ctl[0], 1'b1);
        chg = 1'b0;
        cyc(4);
        chk(ctl[0], 1'b0);
        wctl(8'h01);
        chk(ctl[0], 1'b0);
        $display("change flag test done");
    endtask

    initial
    begin
        cyc(6);
        sys_rst = 1'b0;
        cyc(2);
        tReset();
        tPending();
        tEntry();
        tGroup();
        tSleep();
        tPin();
        tChange();
        conclude();
    end
endmodule

// ---- sim/cic_seq_model.sv ----
// Behavioural CPU sequencer: phase count, cycle boundary and PC.
// Assumes the controller's clock and reset.
`timescale 1ns/10ps
module cic_seq_model
    import cic_pkg::*;
(
    // Clock and reset
    input wire logic clock,
    input wire logic sys_rst,
    // Vector load
    input wire logic loadPc,
    input wire logic [14:0] loadPcData,
    // Timing and PC
    output logic [1:0] phase,
    output logic instrCycleEnd,
    output logic [14:0] currentPc
);
    assign instrCycleEnd = (phase == CIC_PHASE_Q4);

    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
            phase <= CIC_PHASE_RST;
        else
            phase <= phase + 2'h1;
    end

    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
            currentPc <= CIC_PC_RST;
        else if (loadPc)
            currentPc <= loadPcData;
        else if (instrCycleEnd)
            currentPc <= currentPc + 15'h1;
    end
endmodule
